// ==== s2e_error_status.sv ====
`timescale 1ns/1ps
`include "s2e_map.svh"

// Operation
// R1 - Data mover bad address sets bit 6
// R2 - Error clears run, halts gracefully, then flags
// R3 - First failing descriptor address captured only once
// R4 - Flags persist until soft or hard reset
// R5 - Bits 7 and 11 read zero always
// R6 - Completed descriptor fetch sets bit 8, halts
// R7 - Descriptor read slave error sets bit 9
// R8 - Descriptor pointer decode error sets bit 10
// R9 - Descriptor engine errors never written to descriptors
// R10 - No gather engine: bits 8-10 stay zero
// R11 - Flags reset zero, set on error, read-only
// R12 - Writes to status leave flags unchanged
// R13 - Drain outstanding transfers before halted, none new
module s2e_error_status #(
    parameter bit GATHER_ENGINE_PRESENT = 1'b1  // Descriptor engine built in
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        mm_decode_err,
    input  wire logic        desc_complete_seen,
    input  wire logic        desc_slave_err,
    input  wire logic        desc_decode_err,
    input  wire logic [31:0] err_desc_addr,
    input  wire logic        mm_outstanding,
    output logic             run_stop_control_r,
    output logic             engine_stopped_flag_r,
    output logic             xfer_allow_r,
    output logic             desc_wb_fault_r,
    output logic [31:0]      current_descriptor_pointer_r
);
    import s2e_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    s2e_state_t  state_r;              // Engine state
    s2e_state_t  state_nxt;            // Next engine state
    logic        ack_r;                // Bus acknowledge
    logic        ack_nxt;              // Next acknowledge
    logic [31:0] rdata_nxt;            // Read data mux
    logic        srst_r;               // Soft reset pulse
    logic        cap_done_r;           // Failing address already held
    logic        mm_decode_fault;      // Status bit 6
    logic        desc_engine_internal_fault; // Status bit 8
    logic        desc_fetch_slave_fault;     // Status bit 9
    logic        desc_fetch_decode_fault;    // Status bit 10
    logic        any_flag;             // Some error latched
    logic        any_evt;              // Some error this cycle
    logic        desc_evt;             // Descriptor engine error this cycle
    logic        flag_clr;             // Soft reset only
    logic        req;                  // Request seen, not yet acked
    logic        wr_fire;              // Write takes effect
    logic        sel_ctrl;             // Control register hit
    logic        sel_stat;             // Status register hit
    logic        sel_cdesc;            // Pointer register hit
    logic        wr_ctrl;              // Control write
    logic        wr_cdesc;             // Pointer write
    logic        rs_set_req;           // Software asks to run
    logic        rs_clr_req;           // Software asks to stop
    logic        srst_req;             // Software soft reset
    logic [31:0] wmask;                // Byte lane mask
    logic [31:0] cdesc_wr_val;         // Merged pointer write
    logic [31:0] stat_word;            // Assembled status
    logic [31:0] ctrl_word;            // Assembled control
    logic        run_nxt;              // Next run/stop
    logic        halt_nxt;             // Next halted flag
    logic        allow_nxt;            // Next transfer permission
    logic        cap_nxt;              // Next capture marker
    logic [31:0] cdesc_nxt;            // Next pointer

    // ****************************************************************
    // Address decode and bus strobes
    // ****************************************************************
    assign req       = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_fire   = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    assign sel_ctrl  = (wb_adr_i == `S2E_ADR_CTRL);
    // R12 status has no write path
    assign sel_stat  = (wb_adr_i == `S2E_ADR_STAT);
    assign sel_cdesc = (wb_adr_i == `S2E_ADR_CDESC);
    assign wr_ctrl   = wr_fire & sel_ctrl & wb_sel_i[0];
    assign wr_cdesc  = wr_fire & sel_cdesc;
    assign ack_nxt   = req;

    // Lane mask for the pointer register
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign cdesc_wr_val = (wb_dat_i & wmask) | (current_descriptor_pointer_r & ~wmask);

    // Control requests from software
    assign rs_set_req = wr_ctrl & wb_dat_i[`S2E_CTRL_RS];
    assign rs_clr_req = wr_ctrl & ~wb_dat_i[`S2E_CTRL_RS];
    assign srst_req   = wr_ctrl & wb_dat_i[`S2E_CTRL_SRST];

    // ****************************************************************
    // Error events and sticky flags
    // ****************************************************************
    assign flag_clr = srst_r;
    assign desc_evt = GATHER_ENGINE_PRESENT & (desc_complete_seen | desc_slave_err | desc_decode_err);
    assign any_evt  = mm_decode_err | desc_evt;
    assign any_flag = mm_decode_fault | desc_engine_internal_fault
                    | desc_fetch_slave_fault | desc_fetch_decode_fault;

    // R1 data mover decode
    s2e_flag #(.ENABLE(1'b1)) u_mm_dec (
        .clk    (clk),
        .rst    (rst),
        .clr    (flag_clr),
        .set    (mm_decode_err),
        .flag_r (mm_decode_fault)
    );

    // R6 R10 completed descriptor
    s2e_flag #(.ENABLE(GATHER_ENGINE_PRESENT)) u_desc_int (
        .clk    (clk),
        .rst    (rst),
        .clr    (flag_clr),
        .set    (desc_complete_seen),
        .flag_r (desc_engine_internal_fault)
    );

    // R7 R10 descriptor slave error
    s2e_flag #(.ENABLE(GATHER_ENGINE_PRESENT)) u_desc_slv (
        .clk    (clk),
        .rst    (rst),
        .clr    (flag_clr),
        .set    (desc_slave_err),
        .flag_r (desc_fetch_slave_fault)
    );

    // R8 R10 descriptor decode error
    s2e_flag #(.ENABLE(GATHER_ENGINE_PRESENT)) u_desc_dec (
        .clk    (clk),
        .rst    (rst),
        .clr    (flag_clr),
        .set    (desc_decode_err),
        .flag_r (desc_fetch_decode_fault)
    );

    // ****************************************************************
    // Register read words
    // ****************************************************************
    // R5 R11 reserved bits stay zero
    always_comb begin
        stat_word = `S2E_ZERO32;
        stat_word[`S2E_ST_HALT]  = engine_stopped_flag_r;
        stat_word[`S2E_ST_MMDEC] = mm_decode_fault;
        stat_word[`S2E_ST_DINT]  = desc_engine_internal_fault;
        stat_word[`S2E_ST_DSLV]  = desc_fetch_slave_fault;
        stat_word[`S2E_ST_DDEC]  = desc_fetch_decode_fault;
    end

    // Control read-back
    always_comb begin
        ctrl_word = `S2E_ZERO32;
        ctrl_word[`S2E_CTRL_RS] = run_stop_control_r;
    end

    // Read mux; unmapped offsets read zero
    assign rdata_nxt = sel_ctrl  ? ctrl_word :
                       sel_stat  ? stat_word :
                       sel_cdesc ? current_descriptor_pointer_r :
                                   `S2E_ZERO32;

    // ****************************************************************
    // Engine state machine
    // ****************************************************************
    // R2 R13 stop and drain sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S2E_IDLE: begin
                // Start only with no error latched
                if (rs_set_req && !any_flag && !any_evt) begin
                    state_nxt = S2E_RUN;
                end
            end
            S2E_RUN: begin
                // Error or software stop begins a drain
                if (any_evt || rs_clr_req) begin
                    state_nxt = S2E_DRAIN;
                end
            end
            S2E_DRAIN: begin
                // Halt only once the bus is empty
                if (!mm_outstanding) begin
                    state_nxt = S2E_IDLE;
                end
            end
            default: begin
                state_nxt = S2E_IDLE;
            end
        endcase
    end

    // R2 run cleared on error
    assign run_nxt = (any_evt || any_flag) ? 1'b0 :
                     (state_r == S2E_IDLE && rs_set_req) ? 1'b1 :
                     rs_clr_req ? 1'b0 : run_stop_control_r;
    // R2 halted after shut down
    assign halt_nxt  = (state_nxt == S2E_IDLE);
    // R13 no new transfers unless running
    assign allow_nxt = (state_nxt == S2E_RUN);

    // ****************************************************************
    // Failing descriptor capture
    // ****************************************************************
    // R3 single address capture
    assign cap_nxt = cap_done_r | (GATHER_ENGINE_PRESENT & any_evt);
    assign cdesc_nxt = (GATHER_ENGINE_PRESENT && any_evt && !cap_done_r) ? err_desc_addr :
                       (wr_cdesc && state_r == S2E_IDLE && !cap_done_r) ? cdesc_wr_val :
                       current_descriptor_pointer_r;

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Bus answer and read data
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r    <= 1'b0;
            wb_dat_o <= `S2E_ZERO32;
        end else begin
            ack_r    <= ack_nxt;
            wb_dat_o <= req ? rdata_nxt : wb_dat_o;
        end
    end
    assign wb_ack_o = ack_r;

    // Soft reset pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            srst_r <= 1'b0;
        end else begin
            srst_r <= srst_req;
        end
    end

    // R4 engine control, reset by either reset; halted flag loads one
    always_ff @(posedge clk) begin
        if (rst || srst_r) begin
            state_r               <= S2E_IDLE;
            run_stop_control_r    <= 1'b0;
            engine_stopped_flag_r <= `S2E_HALT_RST;
            xfer_allow_r          <= 1'b0;
        end else begin
            state_r               <= state_nxt;
            run_stop_control_r    <= run_nxt;
            engine_stopped_flag_r <= halt_nxt;
            xfer_allow_r          <= allow_nxt;
        end
    end

    // R3 pointer and capture marker
    always_ff @(posedge clk) begin
        if (rst || srst_r) begin
            cap_done_r                   <= 1'b0;
            current_descriptor_pointer_r <= `S2E_PTR_RST;
        end else begin
            cap_done_r                   <= cap_nxt;
            current_descriptor_pointer_r <= cdesc_nxt;
        end
    end

    // R9 only data mover errors reach writeback
    always_ff @(posedge clk) begin
        if (rst || srst_r) begin
            desc_wb_fault_r <= 1'b0;
        end else begin
            desc_wb_fault_r <= mm_decode_fault | mm_decode_err;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_err_seen;
        any_evt && !srst_r;
    endsequence

    property p_mm_dec;
        (mm_decode_err && !srst_r) |=> mm_decode_fault;
    endproperty
    a_mm_dec: assert property (p_mm_dec) else $error("bit 6 not set"); // R1

    property p_rs_clr;
        s_err_seen |=> !run_stop_control_r;
    endproperty
    a_rs_clr: assert property (p_rs_clr) else $error("run not cleared"); // R2

    property p_halt_wait;
        (state_r == S2E_DRAIN && mm_outstanding && !srst_r) |=> !engine_stopped_flag_r;
    endproperty
    a_halt_wait: assert property (p_halt_wait) else $error("halted while busy"); // R13

    property p_capture;
        (s_err_seen and (!cap_done_r && GATHER_ENGINE_PRESENT)) |=>
            current_descriptor_pointer_r == $past(err_desc_addr);
    endproperty
    a_capture: assert property (p_capture) else $error("pointer capture wrong"); // R3

    property p_capture_once;
        (cap_done_r && !srst_r) |=> $stable(current_descriptor_pointer_r);
    endproperty
    a_capture_once: assert property (p_capture_once) else $error("second address captured"); // R3

    property p_sticky;
        (mm_decode_fault && !srst_r) |=> mm_decode_fault;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped"); // R4

    property p_rsv;
        wb_ack_o |-> (!wb_dat_o[`S2E_ST_RSV7] && !wb_dat_o[`S2E_ST_RSV11]) || !$past(sel_stat);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set"); // R5

    property p_desc_int;
        (desc_complete_seen && !srst_r && GATHER_ENGINE_PRESENT) |=> desc_engine_internal_fault;
    endproperty
    a_desc_int: assert property (p_desc_int) else $error("bit 8 not set"); // R6

    property p_desc_slv;
        (desc_slave_err && !srst_r && GATHER_ENGINE_PRESENT) |=> desc_fetch_slave_fault;
    endproperty
    a_desc_slv: assert property (p_desc_slv) else $error("bit 9 not set"); // R7

    property p_desc_dec;
        (desc_decode_err && !srst_r && GATHER_ENGINE_PRESENT) |=> desc_fetch_decode_fault;
    endproperty
    a_desc_dec: assert property (p_desc_dec) else $error("bit 10 not set"); // R8

    property p_no_wb;
        (!mm_decode_fault && !mm_decode_err) |=> !desc_wb_fault_r;
    endproperty
    a_no_wb: assert property (p_no_wb) else $error("descriptor error written back"); // R9

    property p_simple;
        !GATHER_ENGINE_PRESENT |-> !(desc_engine_internal_fault || desc_fetch_slave_fault || desc_fetch_decode_fault);
    endproperty
    a_simple: assert property (p_simple) else $error("gather bit set in simple mode"); // R10

    property p_stat_wr;
        (wr_fire && sel_stat && !any_evt && !srst_r) |=> $stable(stat_word[`S2E_ST_DDEC:`S2E_ST_MMDEC]);
    endproperty
    a_stat_wr: assert property (p_stat_wr) else $error("status write changed flags"); // R12

    property p_no_new;
        (state_r != S2E_RUN) |-> !xfer_allow_r;
    endproperty
    a_no_new: assert property (p_no_new) else $error("transfer allowed while stopped"); // R13

endmodule : s2e_error_status

// ==== s2e_flag.sv ====
`timescale 1ns/1ps
`include "s2e_map.svh"

// Sticky error flag: set by hardware, cleared only by a reset
module s2e_flag #(
    parameter bit ENABLE = 1'b1  // Zero ties the flag low
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clr,
    input  wire logic set,
    output logic      flag_r
);

    // ****************************************************************
    // Flag storage
    // ****************************************************************
    logic flag_nxt;  // Next value

    // Set wins over a clear in the same cycle
    assign flag_nxt = ENABLE & (set | (flag_r & ~clr));

    // Flag register
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= `S2E_FLAG_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule : s2e_flag

// ==== s2e_map.svh ====
`ifndef S2E_MAP_SVH
`define S2E_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses on the Wishbone port)
// ****************************************************************
`define S2E_ADR_CTRL   8'h00
`define S2E_ADR_STAT   8'h04
`define S2E_ADR_CDESC  8'h08

// ****************************************************************
// Control register fields
// ****************************************************************
`define S2E_CTRL_RS    0
`define S2E_CTRL_SRST  2

// ****************************************************************
// Status register fields
// ****************************************************************
`define S2E_ST_HALT    0
`define S2E_ST_MMDEC   6
`define S2E_ST_RSV7    7
`define S2E_ST_DINT    8
`define S2E_ST_DSLV    9
`define S2E_ST_DDEC    10
`define S2E_ST_RSV11   11

// ****************************************************************
// Reset values
// ****************************************************************
`define S2E_ZERO32     32'h0000_0000
`define S2E_PTR_RST    32'h0000_0000
`define S2E_FLAG_RST   1'b0
`define S2E_HALT_RST   1'b1

`endif

// ==== s2e_mm_partner.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Interconnect model: answers with faulty responses on command
// ****************************************************************
module s2e_mm_partner (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [1:0]  kind,
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  hold,
    output logic             mm_decode_err,
    output logic             desc_complete_seen,
    output logic             desc_slave_err,
    output logic             desc_decode_err,
    output logic [31:0]      err_desc_addr,
    output logic             mm_outstanding
);
    logic [3:0] busy_r;  // Cycles the bus still has traffic in flight

    // Responses last one cycle; the address is not held afterwards
    always_ff @(posedge clk) begin
        {mm_decode_err, desc_complete_seen, desc_slave_err, desc_decode_err} <= 4'h0;
        err_desc_addr <= ~err_desc_addr;
        if (rst) begin
            busy_r        <= 4'h0;
            err_desc_addr <= 32'h0000_0000;
        end else if (go) begin
            mm_decode_err      <= (kind == 2'h0);
            desc_complete_seen <= (kind == 2'h1);
            desc_slave_err     <= (kind == 2'h2);
            desc_decode_err    <= (kind == 2'h3);
            err_desc_addr      <= addr;
            busy_r             <= hold;
        end else if (busy_r != 4'h0) begin
            busy_r <= busy_r - 4'h1;
        end
    end

    assign mm_outstanding = (busy_r != 4'h0);
endmodule : s2e_mm_partner

// ==== s2e_pkg.sv ====
package s2e_pkg;

    // ****************************************************************
    // Channel engine states
    // ****************************************************************
    typedef enum logic [1:0] {
        S2E_IDLE  = 2'b00,  // Stopped, halted flag set
        S2E_RUN   = 2'b01,  // Moving data
        S2E_DRAIN = 2'b10   // Graceful stop, waiting for bus to empty
    } s2e_state_t;

endpackage : s2e_pkg

// ==== tb.sv ====
`timescale 1ns/1ps
`include "s2e_map.svh"

// ****************************************************************
// Error status bench
// ****************************************************************
module tb;
    import s2e_pkg::*;
    logic        clk, rst, cyc, stb, we, go;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, rdat2, addr, q, q2;
    logic [1:0]  kind;
    logic [3:0]  hold;
    logic        ack, ack2, mde, dcs, dse, dde, mmo, run, halt, allow, wbf;
    logic [31:0] eaddr, ptr;
    int          n_fail, n_checks, cyc_n;

    always #10 clk = ~clk;

    // ****************************************************************
    // Design with and without the gather engine, plus partner
    // ****************************************************************
    s2e_error_status #(.GATHER_ENGINE_PRESENT(1'b1)) uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .mm_decode_err(mde), .desc_complete_seen(dcs),
        .desc_slave_err(dse), .desc_decode_err(dde), .err_desc_addr(eaddr), .mm_outstanding(mmo),
        .run_stop_control_r(run), .engine_stopped_flag_r(halt), .xfer_allow_r(allow),
        .desc_wb_fault_r(wbf), .current_descriptor_pointer_r(ptr));
    s2e_error_status #(.GATHER_ENGINE_PRESENT(1'b0)) uut2 (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat2), .wb_ack_o(ack2), .mm_decode_err(mde), .desc_complete_seen(dcs),
        .desc_slave_err(dse), .desc_decode_err(dde), .err_desc_addr(eaddr), .mm_outstanding(mmo),
        .run_stop_control_r(), .engine_stopped_flag_r(), .xfer_allow_r(),
        .desc_wb_fault_r(), .current_descriptor_pointer_r());
    s2e_mm_partner mm (.clk(clk), .rst(rst), .go(go), .kind(kind), .addr(addr), .hold(hold),
        .mm_decode_err(mde), .desc_complete_seen(dcs), .desc_slave_err(dse),
        .desc_decode_err(dde), .err_desc_addr(eaddr), .mm_outstanding(mmo));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        q2 = rdat2;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // Soft reset then start the engine
    task automatic start_run;
        wb(1'b1, `S2E_ADR_CTRL, 32'h0000_0004);
        wb(1'b1, `S2E_ADR_CTRL, 32'h0000_0001);
        @(posedge clk);
        #1;
        chk(32'(run), 32'h1);
        chk(32'(allow), 32'h1);
    endtask : start_run

    // Wait for the engine to report halted, bounded
    task automatic wait_halt;
        int n;
        n = 0;
        while (halt !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(halt), 32'h1);
        chk(32'(mmo), 32'h0);
    endtask : wait_halt

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        wb(1'b0, `S2E_ADR_STAT, 32'h0);
        chk(q, 32'h0000_0001);
        wb(1'b0, `S2E_ADR_CDESC, 32'h0);
        chk(q, 32'h0000_0000);
        chk(32'(halt), 32'h1);
    endtask : t_reset

    task automatic t_fault(input int k);
        int bits[4] = '{6, 8, 9, 10};
        logic [31:0] a;
        a = 32'h1000_0040 + 32'(k) * 32'h10;
        start_run;
        @(posedge clk);
        go   <= 1'b1;
        kind <= 2'(k);
        addr <= a;
        hold <= 4'h5;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        chk(32'(run), 32'h0);
        chk(32'(allow), 32'h0);
        chk(32'(halt), 32'h0);
        chk(32'(wbf), 32'(k == 0));
        chk(ptr, a);
        wait_halt;
        wb(1'b0, `S2E_ADR_STAT, 32'h0);
        chk(q, 32'h1 | (32'h1 << bits[k]));
        chk(32'(q2[10:8]), 32'h0);
    endtask : t_fault

    task automatic t_multi;
        start_run;
        @(posedge clk);
        go   <= 1'b1;
        kind <= 2'h2;
        addr <= 32'h2000_0100;
        hold <= 4'h8;
        @(posedge clk);
        kind <= 2'h3;
        addr <= 32'h2000_0200;
        @(posedge clk);
        go <= 1'b0;
        wait_halt;
        wb(1'b0, `S2E_ADR_CDESC, 32'h0);
        chk(q, 32'h2000_0100);
        wb(1'b1, `S2E_ADR_STAT, 32'hffff_ffff);
        wb(1'b0, `S2E_ADR_STAT, 32'h0);
        chk(q, 32'h0000_0601);
        chk(32'({q[11], q[7]}), 32'h0);
        wb(1'b1, `S2E_ADR_CTRL, 32'h0000_0001);
        @(posedge clk);
        #1;
        chk(32'(run), 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, `S2E_ADR_CTRL, 32'h0000_0004);
        wb(1'b0, `S2E_ADR_STAT, 32'h0);
        chk(q, 32'h0000_0001);
        wb(1'b0, `S2E_ADR_CDESC, 32'h0);
        chk(q, 32'h0);
    endtask : t_multi

    // ****************************************************************
    // Verdict, timeout and main sequence
    // ****************************************************************
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // Cut a hang short
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        {clk, cyc, stb, we, go} = 5'h0;
        {adr, wdat, addr, kind, hold} = '0;
        {n_fail, n_checks, cyc_n} = '0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        for (int k = 0; k < 4; k++) t_fault(k);
        t_multi;
        summarize();
    end
endmodule : tb
